// File: verilog/sct_pkg.sv
// Package for the single-cycle core instruction timing decoder
package sct_pkg;

  // Instruction classes as decoded from the opcode
  typedef enum logic [12:0] {
    SCT_ONE     = 13'h0001,
    SCT_TWO     = 13'h0002,
    SCT_LOGIC3  = 13'h0004,
    SCT_BIT     = 13'h0008,
    SCT_JMPIND  = 13'h0010,
    SCT_BR2     = 13'h0020,
    SCT_LONG    = 13'h0040,
    SCT_BITBR   = 13'h0080,
    SCT_CMPBR   = 13'h0100,
    SCT_XDATA   = 13'h0200,
    SCT_ARITH   = 13'h0400,
    SCT_MULDIV  = 13'h0800,
    SCT_OTHER   = 13'h1000
  } sct_class_e;

  // Sequencer state
  typedef enum logic [2:0] {
    SCT_IDLE = 3'h1,
    SCT_BUSY = 3'h2,
    SCT_LAST = 3'h4
  } sct_state_e;

  localparam int          CYC_W          = 5;
  localparam int          WAIT_W         = 3;
  localparam logic [4:0]  CYC_ONE        = 5'h01;
  localparam logic [4:0]  CYC_TWO        = 5'h02;
  localparam logic [4:0]  CYC_THREE      = 5'h03;
  localparam logic [4:0]  CYC_FOUR       = 5'h04;
  localparam logic [4:0]  CYC_MULDIV     = 5'h09;
  localparam logic [1:0]  LEN_ONE        = 2'h1;
  localparam logic [1:0]  LEN_TWO        = 2'h2;
  localparam logic [1:0]  LEN_THREE      = 2'h3;
  localparam logic [7:0]  OP_LCALL       = 8'h12;
  localparam logic [7:0]  OP_JBC         = 8'h10;
  localparam logic [2:0]  WAIT_RESET     = 3'h0;
  localparam logic [4:0]  CNT_RESET      = 5'h00;

  // Decoded timing of one instruction
  typedef struct packed {
    logic [4:0] cycles;
    logic [1:0] length;
    logic       clear_bit;
  } sct_timing_s;

endpackage : sct_pkg

// File: verilog/sct_decoder.sv
// Instruction cycle and length decoder with per-instruction cycle sequencer
`timescale 1ns/10ps

module sct_decoder #(
  parameter int WAIT_W = sct_pkg::WAIT_W
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              issue,
  input  wire logic [7:0]        opcode,
  input  wire logic              from_irq,
  input  wire logic              wait_load,
  input  wire logic [WAIT_W-1:0] wait_value,
  output logic [4:0]             cycles,
  output logic [1:0]             length,
  output logic                   clear_bit,
  output logic                   busy,
  output logic                   last_cycle,
  output logic                   fetch_next,
  output logic [WAIT_W-1:0]      external_wait_states
);

  sct_pkg::sct_class_e  op_class;
  sct_pkg::sct_timing_s dec;
  sct_pkg::sct_state_e  state;
  sct_pkg::sct_state_e  next_state;
  logic [4:0]           remain;
  logic [4:0]           next_remain;
  logic [4:0]           next_cycles;
  logic [1:0]           next_length;
  logic                 next_clear_bit;
  logic                 next_busy;
  logic                 next_last_cycle;
  logic                 next_fetch_next;
  logic [WAIT_W-1:0]    next_wait;

  // Opcode classification; low nibble and high nibble select the 8051 groups
  always_comb begin
    logic [3:0] hi;
    logic [3:0] lo;
    hi = opcode[7:4];
    lo = opcode[3:0];
    op_class = sct_pkg::SCT_OTHER;
    if (lo[3] || lo == 4'h4 || lo == 4'h0 && hi == 4'h0) begin
      op_class = sct_pkg::SCT_ONE;
    end
    if (lo == 4'h1) begin
      op_class = sct_pkg::SCT_BR2;
    end
    unique case (opcode)
      8'h00, 8'hC3, 8'hD3, 8'hB3, 8'hE4, 8'hF4, 8'hC4,
      8'h23, 8'h33, 8'h03, 8'h13, 8'h04, 8'h14: op_class = sct_pkg::SCT_ONE;
      8'h52, 8'h42, 8'h62, 8'h55, 8'h45, 8'h65, 8'h54, 8'h44, 8'h64,
      8'h56, 8'h57, 8'h46, 8'h47, 8'h66, 8'h67: op_class = sct_pkg::SCT_TWO;
      8'h53, 8'h43, 8'h63:                      op_class = sct_pkg::SCT_LOGIC3;
      8'hC2, 8'hD2, 8'hB2, 8'h82, 8'hB0, 8'h72, 8'hA0,
      8'hA2, 8'h92:                             op_class = sct_pkg::SCT_BIT;
      8'h73:                                    op_class = sct_pkg::SCT_JMPIND;
      8'h80, 8'h40, 8'h50, 8'h60, 8'h70:        op_class = sct_pkg::SCT_BR2;
      8'h22, 8'h32, 8'h02, 8'h12:               op_class = sct_pkg::SCT_LONG;
      8'h20, 8'h30, 8'h10:                      op_class = sct_pkg::SCT_BITBR;
      8'hB5, 8'hB4, 8'hB6, 8'hB7, 8'hD5:        op_class = sct_pkg::SCT_CMPBR;
      8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3: op_class = sct_pkg::SCT_XDATA;
      8'h25, 8'h24, 8'h35, 8'h34, 8'h95, 8'h94, 8'h05, 8'h15,
      8'h26, 8'h27, 8'h36, 8'h37, 8'h96, 8'h97, 8'h06, 8'h07,
      8'h16, 8'h17, 8'hD4, 8'hA3:               op_class = sct_pkg::SCT_ARITH;
      8'hA4, 8'h84:                             op_class = sct_pkg::SCT_MULDIV;
      default: begin
        if (lo >= 4'h8 && (hi == 4'hB || hi == 4'hD)) begin
          op_class = (hi == 4'hB) ? sct_pkg::SCT_CMPBR : sct_pkg::SCT_BR2;
        end
      end
    endcase
  end

  // Cycle count and byte length per class, presented at decode
  always_comb begin
    dec.clear_bit = 1'b0;
    dec.cycles    = sct_pkg::CYC_ONE;
    dec.length    = sct_pkg::LEN_ONE;
    unique case (op_class)
      sct_pkg::SCT_ONE: begin
        dec.cycles = sct_pkg::CYC_ONE;
        dec.length = sct_pkg::LEN_ONE;
      end
      sct_pkg::SCT_TWO: begin
        dec.cycles = sct_pkg::CYC_TWO;
        dec.length = (opcode[3:1] == 3'h3) ? sct_pkg::LEN_ONE : sct_pkg::LEN_TWO;
      end
      sct_pkg::SCT_LOGIC3: begin
        dec.cycles = sct_pkg::CYC_THREE;
        dec.length = sct_pkg::LEN_THREE;
      end
      sct_pkg::SCT_BIT: begin
        dec.cycles = sct_pkg::CYC_TWO;
        dec.length = sct_pkg::LEN_TWO;
      end
      sct_pkg::SCT_JMPIND: begin
        dec.cycles = sct_pkg::CYC_THREE;
        dec.length = sct_pkg::LEN_ONE;
      end
      sct_pkg::SCT_BR2: begin
        dec.cycles = sct_pkg::CYC_THREE;
        dec.length = sct_pkg::LEN_TWO;
      end
      sct_pkg::SCT_LONG: begin
        // Interrupt entry skips the stack-fetch cycle of a real call
        if (opcode == sct_pkg::OP_LCALL && from_irq) begin
          dec.cycles = sct_pkg::CYC_THREE;
        end else begin
          dec.cycles = sct_pkg::CYC_FOUR;
        end
        // Long jump and call carry a 16-bit address; returns are one byte
        dec.length = (opcode[7:5] == 3'h0) ? sct_pkg::LEN_THREE : sct_pkg::LEN_ONE;
      end
      sct_pkg::SCT_BITBR: begin
        dec.cycles    = sct_pkg::CYC_FOUR;
        dec.length    = sct_pkg::LEN_THREE;
        dec.clear_bit = (opcode == sct_pkg::OP_JBC);
      end
      sct_pkg::SCT_CMPBR: begin
        dec.cycles = sct_pkg::CYC_FOUR;
        dec.length = sct_pkg::LEN_THREE;
      end
      sct_pkg::SCT_XDATA: begin
        // Wait field is narrow so the sum cannot overflow the count
        dec.cycles = sct_pkg::CYC_FOUR + 5'(external_wait_states);
        dec.length = sct_pkg::LEN_ONE;
      end
      sct_pkg::SCT_ARITH: begin
        dec.cycles = (opcode == 8'hA3) ? sct_pkg::CYC_THREE : sct_pkg::CYC_TWO;
        dec.length = (opcode[3:2] == 2'h1 && opcode[1:0] != 2'h0) ? sct_pkg::LEN_TWO
                   : sct_pkg::LEN_ONE;
      end
      sct_pkg::SCT_MULDIV: begin
        dec.cycles = sct_pkg::CYC_MULDIV;
        dec.length = sct_pkg::LEN_ONE;
      end
      sct_pkg::SCT_OTHER: begin
        dec.cycles = sct_pkg::CYC_TWO;
        dec.length = sct_pkg::LEN_TWO;
      end
    endcase
  end

  // Sequencer: one count per core clock
  always_comb begin
    next_state      = state;
    next_remain     = remain;
    next_cycles     = cycles;
    next_length     = length;
    next_clear_bit  = clear_bit;
    next_wait       = external_wait_states;
    next_fetch_next = 1'b0;
    if (wait_load) begin
      next_wait = wait_value;
    end
    unique case (state)
      sct_pkg::SCT_IDLE, sct_pkg::SCT_LAST: begin
        if (issue) begin
          next_cycles    = dec.cycles;
          next_length    = dec.length;
          next_clear_bit = dec.clear_bit;
          next_remain    = dec.cycles - 5'h01;
          next_state     = (dec.cycles == sct_pkg::CYC_ONE) ? sct_pkg::SCT_LAST
                         : sct_pkg::SCT_BUSY;
          next_fetch_next = (dec.cycles == sct_pkg::CYC_ONE);
        end else begin
          next_state = sct_pkg::SCT_IDLE;
        end
      end
      sct_pkg::SCT_BUSY: begin
        next_remain = remain - 5'h01;
        if (remain == 5'h01) begin
          next_state      = sct_pkg::SCT_LAST;
          next_fetch_next = 1'b1;
        end
      end
      default: next_state = sct_pkg::SCT_IDLE;
    endcase
    next_busy       = (next_state == sct_pkg::SCT_BUSY);
    next_last_cycle = (next_state == sct_pkg::SCT_LAST);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state                <= sct_pkg::SCT_IDLE;
      remain               <= sct_pkg::CNT_RESET;
      cycles               <= sct_pkg::CNT_RESET;
      length               <= 2'h0;
      clear_bit            <= 1'b0;
      busy                 <= 1'b0;
      last_cycle           <= 1'b0;
      fetch_next           <= 1'b0;
      external_wait_states <= WAIT_W'(sct_pkg::WAIT_RESET);
    end else begin
      state                <= next_state;
      remain               <= next_remain;
      cycles               <= next_cycles;
      length               <= next_length;
      clear_bit            <= next_clear_bit;
      busy                 <= next_busy;
      last_cycle           <= next_last_cycle;
      fetch_next           <= next_fetch_next;
      external_wait_states <= next_wait;
    end
  end

endmodule : sct_decoder

// File: tb/sct_decoder_monitor.sv
// Timing checker for the instruction cycle and length decoder
`timescale 1ns/10ps
module sct_decoder_monitor #(
  parameter int WAIT_W = sct_pkg::WAIT_W
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              issue,
  input wire logic [7:0]        opcode,
  input wire logic              from_irq,
  input wire logic              wait_load,
  input wire logic [WAIT_W-1:0] wait_value,
  input wire logic [4:0]        cycles,
  input wire logic [1:0]        length,
  input wire logic              clear_bit,
  input wire logic              busy,
  input wire logic              last_cycle,
  input wire logic              fetch_next,
  input wire logic [WAIT_W-1:0] external_wait_states
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Issue only counts when no instruction is still running
  logic take;
  assign take = issue && !busy;
  property p_irq_call; take && opcode == 8'h12 && from_irq |=> cycles == 5'h03; endproperty
  a_irq_call: assert property (p_irq_call) else $error("irq call count");
  property p_nop; take && opcode == 8'h00 |=> last_cycle && !busy && cycles == 5'h01; endproperty
  a_nop: assert property (p_nop) else $error("nop timing");
  property p_movx;
    take && opcode == 8'hE0 && !wait_load |=> cycles == 5'h04 + 5'($past(external_wait_states));
  endproperty
  a_movx: assert property (p_movx) else $error("xdata count");
  property p_wload; wait_load |=> external_wait_states == $past(wait_value); endproperty
  a_wload: assert property (p_wload) else $error("wait load");
  property p_whold; !wait_load |=> $stable(external_wait_states); endproperty
  a_whold: assert property (p_whold) else $error("wait hold");
  property p_ljmp; take && opcode == 8'h02 |=> busy [*3] ##1 (last_cycle && fetch_next); endproperty
  a_ljmp: assert property (p_ljmp) else $error("long jump run");
  property p_jbc; take && opcode == 8'h10 |=> clear_bit && cycles == 5'h04; endproperty
  a_jbc: assert property (p_jbc) else $error("bit clear branch");
  property p_log3; take && opcode == 8'h53 |=> length == 2'h3 && busy ##1 busy ##1 last_cycle;
  endproperty
  a_log3: assert property (p_log3) else $error("three byte logic");
  property p_fetch; fetch_next |-> last_cycle && !busy; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch outside last");
  c_irq: cover property (take && from_irq);
  c_wait: cover property (wait_load);
  c_b2b: cover property (last_cycle && issue);
endmodule : sct_decoder_monitor

bind sct_decoder sct_decoder_monitor #(.WAIT_W(WAIT_W)) i_mon (
  .clk(clk), .rst_n(rst_n), .issue(issue), .opcode(opcode), .from_irq(from_irq),
  .wait_load(wait_load), .wait_value(wait_value), .cycles(cycles), .length(length),
  .clear_bit(clear_bit), .busy(busy), .last_cycle(last_cycle), .fetch_next(fetch_next),
  .external_wait_states(external_wait_states));

// File: tb/sct_decoder_tb.sv
// Self-checking bench for the instruction cycle and length decoder
`timescale 1ns/10ps
module sct_decoder_tb;
  logic        clk, rst_n, issue, from_irq, wait_load, clear_bit, busy, last_cycle, fetch_next;
  logic [7:0]  opcode;
  logic [2:0]  wait_value, external_wait_states;
  logic [4:0]  cycles;
  logic [1:0]  length;
  int          bad_count, n_tests;
  // Opcode, cycles, bytes
  logic [15:0] rows [58] = '{16'h5811, 16'h4811, 16'h6811, 16'hE411, 16'hF411, 16'hC411,
    16'h2311, 16'h3311, 16'h0311, 16'h1311, 16'hC311, 16'hD311, 16'hB311, 16'h0011,
    16'h5621, 16'h5522, 16'h5422, 16'h5222, 16'h4621, 16'h4522, 16'h4422, 16'h4222,
    16'h6522, 16'h6422, 16'h6222, 16'h5333, 16'h4333, 16'h6333, 16'hC222, 16'hD222,
    16'hB222, 16'h8222, 16'hB022, 16'h7222, 16'hA022, 16'hA222, 16'h9222, 16'h7331,
    16'h1132, 16'h0132, 16'h8032, 16'h4032, 16'h5032, 16'h6032, 16'h7032, 16'hD832,
    16'h2241, 16'h3241, 16'h0243, 16'h1243, 16'h2043, 16'h3043, 16'h1043, 16'hB543,
    16'hB443, 16'hB843, 16'hB643, 16'hD543};
  sct_decoder i_dut (.clk(clk), .rst_n(rst_n), .issue(issue), .opcode(opcode),
    .from_irq(from_irq), .wait_load(wait_load), .wait_value(wait_value), .cycles(cycles),
    .length(length), .clear_bit(clear_bit), .busy(busy), .last_cycle(last_cycle),
    .fetch_next(fetch_next), .external_wait_states(external_wait_states));
  always #10 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic run_op(input logic [7:0] op, input logic irq, input logic [4:0] ec,
                        input logic [1:0] el);
    int n;
    @(posedge clk);
    issue    <= 1'b1;
    opcode   <= op;
    from_irq <= irq;
    @(posedge clk);
    issue    <= 1'b0;
    from_irq <= 1'b0;
    #1;
    n = 1;
    while (last_cycle !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({3'h0, cycles}, {3'h0, ec});
    chk({6'h0, length}, {6'h0, el});
    chk({7'h0, clear_bit}, {7'h0, op == 8'h10});
    chk(8'(n), {3'h0, ec});
    chk({7'h0, fetch_next}, 8'h01);
  endtask : run_op
  task automatic set_wait(input logic [2:0] w);
    @(posedge clk);
    wait_load  <= 1'b1;
    wait_value <= w;
    @(posedge clk);
    wait_load <= 1'b0;
    #1;
    chk({5'h0, external_wait_states}, {5'h0, w});
    run_op(8'hE0, 1'b0, 5'h04 + 5'(w), 2'h1);
  endtask : set_wait
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  // About 5000 cycles, far past the expected run
  initial begin
    #100000;
    bad_count++;
    print_verdict();
  end
  initial begin
    clk = 0; rst_n = 0; issue = 0; opcode = 8'h00; from_irq = 0; wait_load = 0;
    wait_value = 3'h0; bad_count = 0; n_tests = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk({cycles, length, clear_bit}, 8'h00);
    chk({2'h0, busy, last_cycle, fetch_next, external_wait_states}, 8'h00);
    foreach (rows[i]) run_op(rows[i][15:8], 1'b0, {1'b0, rows[i][7:4]}, rows[i][1:0]);
    run_op(8'h12, 1'b1, 5'h03, 2'h3);
    run_op(8'h02, 1'b1, 5'h04, 2'h3);
    set_wait(3'h2);
    set_wait(3'h7);
    set_wait(3'h0);
    // Back-to-back single-cycle ops keep the final-cycle flag up
    @(posedge clk);
    issue  <= 1'b1;
    opcode <= 8'h00;
    repeat (3) begin
      @(posedge clk);
      #1;
      chk({7'h0, last_cycle}, 8'h01);
    end
    // Issue held during a long jump must be ignored
    @(posedge clk);
    opcode <= 8'h02;
    @(posedge clk);
    opcode <= 8'h00;
    repeat (2) @(posedge clk);
    issue <= 1'b0;
    #1;
    chk({3'h0, cycles}, 8'h04);
    chk({7'h0, busy}, 8'h01);
    // Reset in the middle of a running instruction
    rst_n <= 1'b0;
    #1;
    chk({2'h0, busy, last_cycle, fetch_next, external_wait_states}, 8'h00);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk({cycles, length, clear_bit}, 8'h00);
    repeat (4) @(posedge clk);
    print_verdict();
  end
endmodule : sct_decoder_tb
